// ---- dv/ifed_cpu_model.sv ----
// Processor model that accepts vectored requests, lowest number first
`default_nettype none
module ifed_cpu_model (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       en,
    input  wire logic [3:0] delay,
    input  wire logic [6:1] vector_request,
    output var  logic       accept_valid,
    output var  logic [2:0] accept_num
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_reg;
    // Acceptance follows only after the request stood for delay cycles
    always_ff @(posedge clk) begin
        if (!reset_n || !en || accept_valid || vector_request == 6'h00) begin
            accept_valid <= 1'b0;
            accept_num   <= reset_n ? ~accept_num : 3'h0;
            wait_reg     <= 4'h0;
        end else if (wait_reg < delay) begin
            wait_reg <= wait_reg + 4'h1;
        end else begin
            accept_valid <= 1'b1;
            wait_reg     <= 4'h0;
            for (int n = 6; n >= 1; n--) begin
                if (vector_request[n]) begin
                    accept_num <= 3'(n);
                end
            end
        end
    end
endmodule : ifed_cpu_model
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking testbench for the interrupt flag and edge detect block
`default_nettype none
module tb_top;
    import ifed_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, reset_n, instr_tick, standby, bank_en, cpu_en;
    logic        nib_we, nib_re, bit_we, bit_re, bit_wdata, bit_rdata_reg;
    logic        accept_valid, standby_release;
    logic [2:0]  accept_num;
    logic [3:0]  mem_bank, nib_addr, nib_wdata, cpu_delay, nib_rdata_reg;
    logic [5:0]  bit_addr;
    logic [6:1]  vector_request;
    logic [15:0] vector_addr_reg;
    ifed_pins_t  pins;
    ifed_evt_t   evts;
    int          err_total, check_count;
    int          evsrc[5] = '{SRC_BT, SRC_CSI, SRC_T0, SRC_TPG, SRC_WATCH};
    int          vsrc[6] = '{SRC_BT, SRC_PIN0, SRC_PIN1, SRC_CSI, SRC_T0,
                             SRC_TPG};

    ifed_ctrl i_ifed_ctrl (.clk(clk), .reset_n(reset_n), .pins(pins),
        .evts(evts), .instr_tick(instr_tick), .standby(standby),
        .memory_bank_select_enable(bank_en), .mem_bank(mem_bank),
        .nib_we(nib_we), .nib_re(nib_re), .nib_addr(nib_addr),
        .nib_wdata(nib_wdata), .bit_we(bit_we), .bit_re(bit_re),
        .bit_addr(bit_addr), .bit_wdata(bit_wdata),
        .accept_valid(accept_valid), .accept_num(accept_num),
        .vector_request(vector_request), .standby_release(standby_release),
        .nib_rdata_reg(nib_rdata_reg), .bit_rdata_reg(bit_rdata_reg),
        .vector_addr_reg(vector_addr_reg));
    ifed_cpu_model i_ifed_cpu_model (.clk(clk), .reset_n(reset_n),
        .en(cpu_en), .delay(cpu_delay), .vector_request(vector_request),
        .accept_valid(accept_valid), .accept_num(accept_num));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) instr_tick <= reset_n ? ~instr_tick : 1'b0;

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic tend(input string s);
        $display("test %s done", s);
    endtask : tend
    function automatic logic [5:0] baddr(input logic [3:0] b, input int k);
        return {b + 4'(k / 4), 2'(k % 4)};
    endfunction : baddr
    task automatic wr(input logic [3:0] a, input logic [3:0] d);
        @(posedge clk);
        nib_we    <= 1'b1;
        nib_addr  <= a;
        nib_wdata <= d;
        @(posedge clk);
        nib_we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [3:0] exp);
        @(posedge clk);
        nib_re   <= 1'b1;
        nib_addr <= a;
        @(posedge clk);
        nib_re <= 1'b0;
        #1;
        chk({12'h000, nib_rdata_reg}, {12'h000, exp});
    endtask : rd
    task automatic bw(input logic [3:0] b, input int k, input logic v);
        @(posedge clk);
        bit_we    <= 1'b1;
        bit_addr  <= baddr(b, k);
        bit_wdata <= v;
        @(posedge clk);
        bit_we <= 1'b0;
    endtask : bw
    task automatic br(input logic [3:0] b, input int k, input logic exp);
        @(posedge clk);
        bit_re   <= 1'b1;
        bit_addr <= baddr(b, k);
        @(posedge clk);
        bit_re <= 1'b0;
        #1;
        chk({15'h0000, bit_rdata_reg}, {15'h0000, exp});
    endtask : br
    task automatic clear_pend();
        wr(ADDR_PEND, 4'h0);
        wr(ADDR_PEND + 4'h1, 4'h0);
        wr(ADDR_PEND + 4'h2, 4'h0);
    endtask : clear_pend
    task automatic pin_a(input logic v, input int n);
        @(posedge clk);
        pins.ext_pin_a <= v;
        cyc(n);
    endtask : pin_a
    task automatic serve(input logic [15:0] vaddr);
        int i;
        @(posedge clk);
        cpu_en <= 1'b1;
        for (i = 0; i < 40 && accept_valid !== 1'b1; i++) begin
            @(posedge clk);
        end
        cpu_en <= 1'b0;
        if (i == 40) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
            close_out();
        end
        cyc(1);
        chk(vector_addr_reg, vaddr);
    endtask : serve

    initial begin
        repeat (30000) @(posedge clk);
        err_total++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        close_out();
    end

    initial begin
        {reset_n, standby, bank_en, cpu_en, cpu_delay, mem_bank} = '0;
        {nib_we, nib_re, nib_addr, nib_wdata} = '0;
        {bit_we, bit_re, bit_addr, bit_wdata} = '0;
        {err_total, check_count} = '0;
        pins = 12'h0ff;
        evts = '0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        for (int a = 0; a < 3; a++) rd(4'(a), 4'h0);
        for (int a = 6; a < 9; a++) rd(4'(a), 4'h0);
        for (int j = 0; j < 5; j++) br(ADDR_PEND, evsrc[j], 1'b0);
        br(ADDR_PEND, SRC_PIN0, 1'b0);
        rd(4'hf, 4'h0);
        clear_pend();
        tend("reset");
        for (int j = 0; j < 5; j++) begin
            @(posedge clk);
            evts <= ifed_evt_t'(5'h10 >> j);
            @(posedge clk);
            evts <= '0;
            cyc(1);
            chk({9'h0, standby_release, vector_request}, 16'h0000);
            br(ADDR_PEND, evsrc[j], 1'b1);
        end
        clear_pend();
        tend("events");
        for (int n = 1; n <= 6; n++) begin
            cpu_delay <= (n % 2 == 1) ? 4'h3 : 4'h0;
            bw(ADDR_PEND, vsrc[n - 1], 1'b1);
            bw(ADDR_PERMIT, vsrc[n - 1], 1'b1);
            cyc(1);
            chk({9'h0, standby_release, vector_request},
                {9'h0, 1'b1, 6'h01 << (n - 1)});
            serve(16'(2 * n));
            br(ADDR_PEND, vsrc[n - 1], 1'b0);
            bw(ADDR_PERMIT, vsrc[n - 1], 1'b0);
        end
        tend("vectors");
        wr(ADDR_PEND, 4'h3);
        wr(ADDR_PERMIT, 4'h3);
        cyc(1);
        chk({10'h0, vector_request}, 16'h0001);
        serve(16'h0002);
        rd(ADDR_PEND, 4'h3);
        wr(ADDR_PERMIT, 4'h0);
        clear_pend();
        tend("shared");
        bw(ADDR_PEND, SRC_KEY, 1'b1);
        bw(ADDR_PEND, SRC_WATCH, 1'b1);
        bw(ADDR_PERMIT, SRC_KEY, 1'b1);
        bw(ADDR_PERMIT, SRC_WATCH, 1'b1);
        cyc(1);
        chk({9'h0, standby_release, vector_request}, 16'h0040);
        wr(ADDR_PERMIT + 4'h1, 4'h0);
        wr(ADDR_PERMIT + 4'h2, 4'h0);
        clear_pend();
        tend("test_only");
        for (int j = 0; j < 2; j++) begin
            @(posedge clk);
            pins.ext_pin_bothedge <= ~pins.ext_pin_bothedge;
            cyc(4);
            br(ADDR_PEND, SRC_BOTH, 1'b1);
            bw(ADDR_PEND, SRC_BOTH, 1'b0);
        end
        @(posedge clk);
        pins.ext_pin_b <= 1'b1;
        cyc(4);
        br(ADDR_PEND, SRC_PIN1, 1'b1);
        wr(ADDR_MODE1, 4'h1);
        bw(ADDR_PEND, SRC_PIN1, 1'b0);
        @(posedge clk);
        pins.ext_pin_b <= 1'b0;
        cyc(4);
        br(ADDR_PEND, SRC_PIN1, 1'b1);
        bw(ADDR_PEND, SRC_PIN1, 1'b0);
        @(posedge clk);
        pins.ext_pin_b <= 1'b1;
        cyc(4);
        br(ADDR_PEND, SRC_PIN1, 1'b0);
        wr(ADDR_MODE1, 4'h2);
        @(posedge clk);
        pins.ext_pin_b <= 1'b0;
        cyc(4);
        br(ADDR_PEND, SRC_PIN1, 1'b0);
        tend("pins");
        pin_a(1'b1, 1);
        pin_a(1'b0, 12);
        br(ADDR_PEND, SRC_PIN0, 1'b0);
        pin_a(1'b1, 12);
        br(ADDR_PEND, SRC_PIN0, 1'b1);
        bw(ADDR_PEND, SRC_PIN0, 1'b0);
        pin_a(1'b0, 12);
        br(ADDR_PEND, SRC_PIN0, 1'b0);
        wr(ADDR_MODE0, 4'h1);
        bw(ADDR_PEND, SRC_PIN0, 1'b0);
        pin_a(1'b1, 12);
        br(ADDR_PEND, SRC_PIN0, 1'b0);
        pin_a(1'b0, 12);
        br(ADDR_PEND, SRC_PIN0, 1'b1);
        wr(ADDR_MODE0, 4'h8);
        cyc(16);
        bw(ADDR_PEND, SRC_PIN0, 1'b0);
        pin_a(1'b1, 40);
        pin_a(1'b0, 300);
        br(ADDR_PEND, SRC_PIN0, 1'b0);
        pin_a(1'b1, 300);
        br(ADDR_PEND, SRC_PIN0, 1'b1);
        pin_a(1'b0, 300);
        wr(ADDR_MODE0, 4'h0);
        bw(ADDR_PEND, SRC_PIN0, 1'b0);
        bw(ADDR_PERMIT, SRC_PIN0, 1'b1);
        @(posedge clk);
        standby <= 1'b1;
        pin_a(1'b1, 20);
        chk({15'h0, standby_release}, 16'h0000);
        br(ADDR_PEND, SRC_PIN0, 1'b0);
        pin_a(1'b0, 20);
        standby <= 1'b0;
        bw(ADDR_PERMIT, SRC_PIN0, 1'b0);
        tend("pin0");
        wr(ADDR_MODE2, 4'h8);
        bw(ADDR_PEND, SRC_KEY, 1'b0);
        @(posedge clk);
        pins.key_inputs[0] <= 1'b0;
        cyc(4);
        br(ADDR_PEND, SRC_KEY, 1'b1);
        bw(ADDR_PEND, SRC_KEY, 1'b0);
        @(posedge clk);
        pins.key_inputs[1] <= 1'b0;
        cyc(4);
        br(ADDR_PEND, SRC_KEY, 1'b0);
        @(posedge clk);
        pins.key_inputs <= 8'hff;
        wr(ADDR_MODE2, 4'h0);
        bw(ADDR_PEND, SRC_KEY, 1'b0);
        @(posedge clk);
        pins.ext_pin_c <= 1'b1;
        cyc(4);
        br(ADDR_PEND, SRC_KEY, 1'b1);
        tend("key");
        @(posedge clk);
        bank_en <= 1'b1;
        wr(ADDR_PERMIT, 4'hf);
        br(ADDR_PERMIT, SRC_BT, 1'b0);
        bw(ADDR_PERMIT, SRC_BT, 1'b1);
        br(ADDR_PERMIT, SRC_BT, 1'b1);
        mem_bank <= 4'hf;
        rd(ADDR_PERMIT, 4'h1);
        wr(ADDR_PERMIT, 4'h0);
        bank_en <= 1'b0;
        tend("bank");
        @(posedge clk);
        evts.pulsegen_match_event <= 1'b1;
        nib_we    <= 1'b1;
        nib_addr  <= ADDR_PEND + 4'h1;
        nib_wdata <= 4'h0;
        @(posedge clk);
        evts   <= '0;
        nib_we <= 1'b0;
        br(ADDR_PEND, SRC_TPG, 1'b1);
        @(posedge clk);
        evts.timer_match_event <= 1'b1;
        bit_we    <= 1'b1;
        bit_addr  <= baddr(ADDR_PEND, SRC_T0);
        bit_wdata <= 1'b0;
        @(posedge clk);
        evts   <= '0;
        bit_we <= 1'b0;
        br(ADDR_PEND, SRC_T0, 1'b1);
        tend("set_wins");
        close_out();
    end
endmodule : tb_top
`default_nettype wire

// ---- pkg/ifed_pkg.sv ----
// Constants and carrier types for the interrupt flag and edge detect block
`default_nettype none
package ifed_pkg;
    localparam int NSRC      = 9;
    localparam int SRC_BT    = 0;
    localparam int SRC_BOTH  = 1;
    localparam int SRC_PIN0  = 2;
    localparam int SRC_PIN1  = 3;
    localparam int SRC_CSI   = 4;
    localparam int SRC_T0    = 5;
    localparam int SRC_TPG   = 6;
    localparam int SRC_KEY   = 7;
    localparam int SRC_WATCH = 8;

    localparam logic [3:0] ADDR_MODE0  = 4'h0;
    localparam logic [3:0] ADDR_MODE1  = 4'h1;
    localparam logic [3:0] ADDR_MODE2  = 4'h2;
    localparam logic [3:0] ADDR_PEND   = 4'h3;
    localparam logic [3:0] ADDR_PERMIT = 4'h6;
    localparam logic [3:0] FLAG_NIBS   = 4'h3;

    localparam logic [3:0]      MODE_RESET   = 4'h0;
    localparam logic [NSRC-1:0] PEND_RESET   = 9'h000;
    localparam logic [NSRC-1:0] PERMIT_RESET = 9'h000;

    localparam int SAMPLE_CLK_SEL = 3;
    localparam int KEY_MODE_BIT   = 3;
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;

    localparam int FX_DIV = 64;
    localparam int DIV_W  = 6;

    localparam logic [2:0] VEC_FIRST = 3'h1;
    localparam logic [2:0] VEC_LAST  = 3'h6;
    localparam int         VADDR_W   = 16;

    typedef struct packed {
        logic interval_timer_event;
        logic serial_done_event;
        logic timer_match_event;
        logic pulsegen_match_event;
        logic watch_timer_event;
    } ifed_evt_t;

    typedef struct packed {
        logic       ext_pin_a;
        logic       ext_pin_b;
        logic       ext_pin_c;
        logic       ext_pin_bothedge;
        logic [7:0] key_inputs;
    } ifed_pins_t;

    function automatic logic [VADDR_W-1:0] vector_table_addr(
        input logic [2:0] n);
        return {12'h000, n, 1'b0};
    endfunction : vector_table_addr
endpackage : ifed_pkg
`default_nettype wire

// ---- verilog/ifed_ctrl.sv ----
// Interrupt pending and permit flags with external edge detectors
`default_nettype none
module ifed_ctrl #(
    parameter logic [3:0] IO_BANK = 4'hf
) (
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    input  wire ifed_pkg::ifed_pins_t      pins,
    input  wire ifed_pkg::ifed_evt_t       evts,
    input  wire logic                      instr_tick,
    input  wire logic                      standby,
    input  wire logic                      memory_bank_select_enable,
    input  wire logic [3:0]                mem_bank,
    input  wire logic                      nib_we,
    input  wire logic                      nib_re,
    input  wire logic [3:0]                nib_addr,
    input  wire logic [3:0]                nib_wdata,
    input  wire logic                      bit_we,
    input  wire logic                      bit_re,
    input  wire logic [5:0]                bit_addr,
    input  wire logic                      bit_wdata,
    input  wire logic                      accept_valid,
    input  wire logic [2:0]                accept_num,
    output logic [6:1]                     vector_request,
    output logic                           standby_release,
    output logic [3:0]                     nib_rdata_reg,
    output logic                           bit_rdata_reg,
    output logic [ifed_pkg::VADDR_W-1:0]   vector_addr_reg
);
    import ifed_pkg::*;

    ifed_pins_t       pins_s1, pins_s2, pins_s3;
    logic [3:0]       mode0_reg, mode1_reg, mode2_reg;
    logic [NSRC-1:0]  pend_reg, permit_reg, req;
    logic [NSRC-1:0]  hw_set, acc_clr;
    logic [NSRC-1:0]  pend_wr, pend_val, perm_wr, perm_val;
    logic [DIV_W-1:0] div_reg;
    logic             fx_tick, samp_tick, nib_ok, nib_wr;
    logic             smp_reg, filt_reg, filt_d_reg;
    logic [7:0]       key_mask;
    logic             keys_all_hi, keys_hi_d_reg, key_fall, pin2_rise;
    logic [3:0]       nib_rd, bit_nib;

    function automatic logic edge_hit(input logic [1:0] m,
                                      input logic now, input logic was);
        return (m == EDGE_RISE && now && !was) ||
               (m == EDGE_FALL && !now && was);
    endfunction : edge_hit

    function automatic logic [3:0] rd_mux(input logic [3:0] a,
        input logic [3:0] m0, input logic [3:0] m1, input logic [3:0] m2,
        input logic [11:0] pp, input logic [11:0] ep);
        logic [3:0] op, oe;
        op = a - ADDR_PEND;
        oe = a - ADDR_PERMIT;
        if (a == ADDR_MODE0)
            return m0;
        else if (a == ADDR_MODE1)
            return m1;
        else if (a == ADDR_MODE2)
            return m2;
        else if (a >= ADDR_PEND && op < FLAG_NIBS)
            return pp[{op[1:0], 2'b00} +: 4];
        else if (a >= ADDR_PERMIT && oe < FLAG_NIBS)
            return ep[{oe[1:0], 2'b00} +: 4];
        return 4'h0;
    endfunction : rd_mux

    // Pin synchroniser
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pins_s1 <= '0;
            pins_s2 <= '0;
            pins_s3 <= '0;
        end else begin
            pins_s1 <= pins;
            pins_s2 <= pins_s1;
            pins_s3 <= pins_s2;
        end
    end

    // Nibble access honours bank select, bit access does not
    assign nib_ok = !memory_bank_select_enable || mem_bank == IO_BANK;
    assign nib_wr = nib_we && nib_ok;

    // Edge mode registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mode0_reg <= MODE_RESET;
            mode1_reg <= MODE_RESET;
            mode2_reg <= MODE_RESET;
        end else if (nib_wr) begin
            if (nib_addr == ADDR_MODE0)
                mode0_reg <= nib_wdata;
            if (nib_addr == ADDR_MODE1)
                mode1_reg <= nib_wdata;
            if (nib_addr == ADDR_MODE2)
                mode2_reg <= nib_wdata;
        end
    end

    // Oscillator divide-by-64 sample enable
    always_ff @(posedge clk) begin
        if (!reset_n)
            div_reg <= '0;
        else
            div_reg <= div_reg + 1'b1;
    end
    assign fx_tick   = div_reg == DIV_W'(FX_DIV - 1);
    assign samp_tick = !standby &&
        (mode0_reg[SAMPLE_CLK_SEL] ? fx_tick : instr_tick);

    // Pin0 noise filter: output follows two equal samples
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            smp_reg    <= 1'b0;
            filt_reg   <= 1'b0;
            filt_d_reg <= 1'b0;
        end else begin
            filt_d_reg <= filt_reg;
            if (samp_tick) begin
                smp_reg <= pins_s2.ext_pin_a;
                if (smp_reg == pins_s2.ext_pin_a)
                    filt_reg <= smp_reg;
            end
        end
    end

    // Key group: keys n..7 selected, fall when all-high is lost
    assign key_mask    = 8'hff << mode2_reg[2:0];
    assign keys_all_hi = &(pins_s2.key_inputs | ~key_mask);
    always_ff @(posedge clk) begin
        if (!reset_n)
            keys_hi_d_reg <= 1'b1;
        else
            keys_hi_d_reg <= keys_all_hi;
    end
    assign key_fall  = mode2_reg[KEY_MODE_BIT] && keys_hi_d_reg &&
                       !keys_all_hi;
    assign pin2_rise = !mode2_reg[KEY_MODE_BIT] &&
                       pins_s2.ext_pin_c && !pins_s3.ext_pin_c;

    // Hardware set sources; a mode change can yield a spurious edge
    always_comb begin
        hw_set            = '0;
        hw_set[SRC_BT]    = evts.interval_timer_event;
        hw_set[SRC_BOTH]  = pins_s2.ext_pin_bothedge ^
                            pins_s3.ext_pin_bothedge;
        hw_set[SRC_PIN0]  = edge_hit(mode0_reg[1:0], filt_reg,
                                     filt_d_reg);
        hw_set[SRC_PIN1]  = edge_hit(mode1_reg[1:0], pins_s2.ext_pin_b,
                                     pins_s3.ext_pin_b);
        hw_set[SRC_CSI]   = evts.serial_done_event;
        hw_set[SRC_T0]    = evts.timer_match_event;
        hw_set[SRC_TPG]   = evts.pulsegen_match_event;
        hw_set[SRC_KEY]   = pin2_rise || key_fall;
        hw_set[SRC_WATCH] = evts.watch_timer_event;
    end

    // Acceptance clears the serviced flag; vector 1 clears neither flag when SRC_BT and SRC_BOTH are both permitted
    always_comb begin
        acc_clr = '0;
        if (accept_valid) begin
            if (accept_num == VEC_FIRST) begin
                if (!(permit_reg[SRC_BT] && permit_reg[SRC_BOTH])) begin
                    acc_clr[SRC_BT]   = permit_reg[SRC_BT];
                    acc_clr[SRC_BOTH] = permit_reg[SRC_BOTH];
                end
            end else if (accept_num <= VEC_LAST && accept_num != 3'h0) begin
                acc_clr[accept_num] = 1'b1;
            end
        end
    end

    // Software flag writes by nibble or by bit
    always_comb begin
        logic [3:0] pa, ea;
        logic       wv;
        pa = '0;
        ea = '0;
        wv = 1'b0;
        pend_wr  = '0;
        pend_val = '0;
        perm_wr  = '0;
        perm_val = '0;
        for (int i = 0; i < NSRC; i++) begin
            pa = ADDR_PEND + 4'(i / 4);
            ea = ADDR_PERMIT + 4'(i / 4);
            wv = (nib_wr && nib_addr == pa) ? nib_wdata[i % 4] : bit_wdata;
            if ((nib_wr && nib_addr == pa) ||
                (bit_we && bit_addr == {pa, 2'(i % 4)})) begin
                pend_wr[i]  = 1'b1;
                pend_val[i] = wv;
            end
            if ((nib_wr && nib_addr == ea) ||
                (bit_we && bit_addr == {ea, 2'(i % 4)})) begin
                perm_wr[i]  = 1'b1;
                perm_val[i] = (nib_wr && nib_addr == ea) ?
                              nib_wdata[i % 4] : bit_wdata;
            end
        end
    end

    // Pending flags: set beats any clear
    always_ff @(posedge clk) begin
        if (!reset_n)
            pend_reg <= PEND_RESET;
        else
            pend_reg <= hw_set | (pend_wr & pend_val) |
                (pend_reg & ~acc_clr & ~(pend_wr & ~pend_val));
    end

    // Permit flags
    always_ff @(posedge clk) begin
        if (!reset_n)
            permit_reg <= PERMIT_RESET;
        else
            permit_reg <= (permit_reg & ~perm_wr) | (perm_wr & perm_val);
    end

    // Requests; key and watch sources only release standby
    assign req                = pend_reg & permit_reg;
    assign vector_request[1]  = req[SRC_BT] | req[SRC_BOTH];
    assign vector_request[6:2] = req[SRC_TPG:SRC_PIN0];
    assign standby_release    = |req;

    // Register reads
    assign nib_rd  = rd_mux(nib_addr, mode0_reg, mode1_reg, mode2_reg,
                            12'(pend_reg), 12'(permit_reg));
    assign bit_nib = rd_mux(bit_addr[5:2], mode0_reg, mode1_reg, mode2_reg,
                            12'(pend_reg), 12'(permit_reg));
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            nib_rdata_reg <= 4'h0;
            bit_rdata_reg <= 1'b0;
        end else begin
            if (nib_re && nib_ok)
                nib_rdata_reg <= nib_rd;
            if (bit_re)
                bit_rdata_reg <= bit_nib[bit_addr[1:0]];
        end
    end

    // Vector table address of the accepted request
    always_ff @(posedge clk) begin
        if (!reset_n)
            vector_addr_reg <= '0;
        else if (accept_valid && accept_num >= VEC_FIRST &&
                 accept_num <= VEC_LAST)
            vector_addr_reg <= vector_table_addr(accept_num);
    end

    property p_req_pin0;
        @(posedge clk) disable iff (!reset_n)
        pend_reg[SRC_PIN0] && permit_reg[SRC_PIN0] |-> vector_request[2];
    endproperty
    a_req_pin0: assert property (p_req_pin0)
        else $error("pin0 request missing");

    property p_wake;
        @(posedge clk) disable iff (!reset_n)
        req[SRC_WATCH] && req[SRC_TPG:SRC_BT] == '0
            |-> standby_release && vector_request == 6'h00;
    endproperty
    a_wake: assert property (p_wake)
        else $error("watch source did not release standby");

    property p_serial_set;
        @(posedge clk) disable iff (!reset_n)
        evts.serial_done_event |=> pend_reg[SRC_CSI];
    endproperty
    a_serial_set: assert property (p_serial_set)
        else $error("serial strobe lost");

    property p_both_edge;
        @(posedge clk) disable iff (!reset_n)
        pins_s2.ext_pin_bothedge != pins_s3.ext_pin_bothedge
            |=> pend_reg[SRC_BOTH];
    endproperty
    a_both_edge: assert property (p_both_edge)
        else $error("both-edge transition missed");

    property p_permit_reset;
        @(posedge clk) !reset_n |=> permit_reg == PERMIT_RESET;
    endproperty
    a_permit_reset: assert property (p_permit_reset)
        else $error("permit not cleared by reset");

    property p_shared_keep;
        @(posedge clk) disable iff (!reset_n)
        accept_valid && accept_num == VEC_FIRST && permit_reg[SRC_BT] &&
        permit_reg[SRC_BOTH] && !nib_wr && !bit_we
            |=> pend_reg[SRC_BOTH:SRC_BT] >= $past(pend_reg[SRC_BOTH:SRC_BT]);
    endproperty
    a_shared_keep: assert property (p_shared_keep)
        else $error("shared flags changed on accept");

    property p_accept_clear;
        @(posedge clk) disable iff (!reset_n)
        accept_valid && accept_num == 3'h4 && !evts.serial_done_event &&
        !nib_wr && !bit_we |=> !pend_reg[SRC_CSI];
    endproperty
    a_accept_clear: assert property (p_accept_clear)
        else $error("serial flag not cleared on accept");

    property p_set_wins;
        @(posedge clk) disable iff (!reset_n)
        evts.timer_match_event && bit_we && !bit_wdata &&
        bit_addr == {ADDR_PEND + 4'h1, 2'h1} |=> pend_reg[SRC_T0];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("set lost to clear");

    property p_mode0_write;
        @(posedge clk) disable iff (!reset_n)
        nib_wr && nib_addr == ADDR_MODE0 |=> mode0_reg == $past(nib_wdata);
    endproperty
    a_mode0_write: assert property (p_mode0_write)
        else $error("pin0 mode write lost");

    property p_standby_hold;
        @(posedge clk) disable iff (!reset_n)
        standby [*2] |-> $stable(filt_reg);
    endproperty
    a_standby_hold: assert property (p_standby_hold)
        else $error("pin0 filter moved in standby");

    property p_vec_addr;
        @(posedge clk) disable iff (!reset_n)
        accept_valid && accept_num == 3'h5
            |=> vector_addr_reg == 16'h000a;
    endproperty
    a_vec_addr: assert property (p_vec_addr)
        else $error("wrong vector address");
endmodule : ifed_ctrl
`default_nettype wire
